// file: design/admx_bus.sv
// Purpose: Runs multiplexed address/data bus cycles for areas 3 to 7
// Assumes: One access at a time; request held until done pulses
// Notes: Data phase follows the basic bus timing settings
`timescale 1ns/100ps
module admx_bus
  import admx_pkg::*;
#(
  parameter int ADDR_W = `ADMX_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire admx_req_s req,
  output logic req_done,
  output logic [`ADMX_DATA_W-1:0] rdata,
  input wire logic [`ADMX_AREAS-1:0] area_mux_enable,
  input wire logic address_cycle_extend,
  input wire admx_cfg_s cfg,
  output logic [ADDR_W-1:0] addr_out,
  output logic [`ADMX_DATA_W-1:0] data_out,
  output logic [`ADMX_DATA_W-1:0] data_oe,
  input wire logic [`ADMX_DATA_W-1:0] data_in,
  output logic [`ADMX_AREAS-1:0] area_select_n,
  output logic address_hold_strobe_n,
  output logic read_strobe_n,
  output logic read_write_n,
  output logic upper_byte_write_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic cycle_start_flag_n,
  input wire logic wait_n
);
  // Elaboration check: the request carries a fixed-width address
  if (ADDR_W != `ADMX_ADDR_W) begin : g_addr_w_check
    $error("ADDR_W must match address bus");
  end

  // ========================================================
  // Input synchronisers
  logic wait_meta_q, wait_sync_q;
  logic [`ADMX_DATA_W-1:0] din_meta_q, din_sync_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_meta_q <= 1'b1;
      wait_sync_q <= 1'b1;
      din_meta_q <= 16'h0000;
      din_sync_q <= 16'h0000;
    end else begin
      wait_meta_q <= wait_n;
      wait_sync_q <= wait_meta_q;
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // ========================================================
  // Request latch and per-area settings
  admx_state_e state_q;
  admx_req_s cur_q;
  logic [`ADMX_WAIT_W-1:0] wcnt_q;
  logic [2:0] ar;
  logic narrow, any_mux, start;
  logic [1:0] fin_q;
  assign ar = cur_q.area;
  assign narrow = cfg.area_width_high[ar] & cfg.area_width_low[ar];
  assign any_mux = |area_mux_enable[`ADMX_LAST_AREA:`ADMX_FIRST_AREA];
  // No new start while a finished access is still draining
  assign start = (state_q == ADMX_IDLE) && req_valid &&
                 (fin_q == 2'b00) && !req_done &&
                 (req.area >= 3'(`ADMX_FIRST_AREA)) &&
                 area_mux_enable[req.area];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= '0;
    end else if (start) begin
      cur_q <= req;
    end
  end

  // ========================================================
  // Cycle state machine
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ADMX_IDLE;
      wcnt_q <= 3'h0;
    end else begin
      case (state_q)
        ADMX_IDLE: begin
          if (start) begin
            state_q <= cfg.csx_head[req.area] ? ADMX_CSX_PRE
                                              : ADMX_ADDR_ONE;
          end
        end
        ADMX_CSX_PRE: state_q <= ADMX_ADDR_ONE;
        ADMX_ADDR_ONE: begin
          // Address phase gains one state only when address_cycle_extend is set; waits ignored here
          state_q <= address_cycle_extend ? ADMX_ADDR_WAIT
                                          : ADMX_ADDR_TWO;
        end
        ADMX_ADDR_WAIT: state_q <= ADMX_ADDR_TWO;
        ADMX_ADDR_TWO: state_q <= ADMX_DATA_ONE;
        ADMX_DATA_ONE: state_q <= ADMX_DATA_TWO;
        ADMX_DATA_TWO: begin
          wcnt_q <= cfg.prog_waits[ar*`ADMX_WAIT_W +: `ADMX_WAIT_W];
          if (!cfg.three_state[ar]) begin
            state_q <= cfg.csx_tail[ar] ? ADMX_CSX_POST : ADMX_IDLE;
          end else if (cfg.prog_waits[ar*`ADMX_WAIT_W +: `ADMX_WAIT_W]
                       != 3'h0 || (cfg.pin_wait_enable && !wait_sync_q)) begin
            state_q <= ADMX_DATA_WAIT;
          end else begin
            state_q <= ADMX_DATA_THREE;
          end
        end
        ADMX_DATA_WAIT: begin
          if (wcnt_q != 3'h0) begin
            wcnt_q <= wcnt_q - 3'h1;
          end
          if ((wcnt_q <= 3'h1) &&
              !(cfg.pin_wait_enable && !wait_sync_q)) begin
            state_q <= ADMX_DATA_THREE;
          end
        end
        ADMX_DATA_THREE: begin
          state_q <= cfg.csx_tail[ar] ? ADMX_CSX_POST : ADMX_IDLE;
        end
        ADMX_CSX_POST: state_q <= ADMX_IDLE;
        default: state_q <= ADMX_IDLE;
      endcase
    end
  end

  // ========================================================
  // Phase decode for the pin drivers
  logic in_addr, in_data, in_cycle, last_data, rd_on;
  assign in_addr = (state_q == ADMX_ADDR_ONE) ||
                   (state_q == ADMX_ADDR_WAIT) ||
                   (state_q == ADMX_ADDR_TWO);
  assign in_data = (state_q == ADMX_DATA_ONE) ||
                   (state_q == ADMX_DATA_TWO) ||
                   (state_q == ADMX_DATA_WAIT) ||
                   (state_q == ADMX_DATA_THREE);
  assign in_cycle = in_addr || in_data || (state_q == ADMX_CSX_PRE) ||
                    (state_q == ADMX_CSX_POST);
  assign last_data = (state_q == ADMX_DATA_THREE) ||
                     ((state_q == ADMX_DATA_TWO) && !cfg.three_state[ar]);
  // Late negation keeps the read strobe on through the last data state
  assign rd_on = in_data && !cur_q.write &&
                 (!last_data || cfg.read_negation_late[ar]);

  // Registered pin outputs, set one clock after the state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr_out <= '0;
      data_out <= 16'h0000;
      data_oe <= 16'h0000;
      area_select_n <= 8'hFF;
      address_hold_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      read_write_n <= 1'b1;
      upper_byte_write_strobe_n <= 1'b1;
      lower_byte_write_strobe_n <= 1'b1;
      cycle_start_flag_n <= 1'b1;
    end else begin
      addr_out <= in_cycle ? cur_q.addr : addr_out;
      area_select_n <= 8'hFF;
      if (in_cycle) begin
        area_select_n[ar] <= 1'b0;
      end
      // Hold behaviour once any area is mux; plain strobe before
      address_hold_strobe_n <= !(in_addr &&
                                 (any_mux || state_q != ADMX_ADDR_TWO));
      cycle_start_flag_n <= !(state_q == ADMX_ADDR_ONE);
      read_write_n <= !(in_cycle && cur_q.write);
      read_strobe_n <= !rd_on;
      upper_byte_write_strobe_n <= !(in_data && cur_q.write &&
          cur_q.upper_valid && !narrow && !last_data);
      lower_byte_write_strobe_n <= !(in_data && cur_q.write &&
          cur_q.lower_valid && !last_data);
      if (in_addr) begin
        data_out <= narrow ? {8'h00, cur_q.addr[7:0]}
                           : cur_q.addr[15:0];
        data_oe <= narrow ? 16'h00FF : 16'hFFFF;
      end else if (in_data && cur_q.write) begin
        data_out <= narrow ? {8'h00, cur_q.wdata[7:0]} : cur_q.wdata;
        data_oe <= narrow ? 16'h00FF : 16'hFFFF;
      end else begin
        data_out <= 16'h0000;
        data_oe <= 16'h0000;
      end
    end
  end

  // ========================================================
  // Read data capture and completion
  // Pin data takes two clocks through the synchroniser, so completion
  // waits in a two-stage pipe before the read word is taken
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fin_q <= 2'b00;
    end else begin
      fin_q <= {fin_q[0], in_data && last_data};
    end
  end

  // Completion pulse and read word from the synchronised pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
      req_done <= 1'b0;
    end else begin
      req_done <= fin_q[1];
      if (fin_q[1] && !cur_q.write) begin
        rdata <= narrow ? {8'h00, din_sync_q[7:0]} : din_sync_q;
      end
    end
  end
endmodule

// file: design/admx_params.svh
// Purpose: Constants for the multiplexed address/data bus controller
// Assumes: 100 MHz ref_clk
// Notes: Areas 3 to 7 may run multiplexed
`ifndef ADMX_PARAMS_SVH
`define ADMX_PARAMS_SVH
// ==========================================================
// Area range and field widths
`define ADMX_FIRST_AREA 3
`define ADMX_LAST_AREA 7
`define ADMX_AREAS 8
`define ADMX_ADDR_W 24
`define ADMX_DATA_W 16
`define ADMX_WAIT_W 3
// ==========================================================
// Reset values of the configuration
`define ADMX_MUX_EN_RST 8'h00
`endif

// file: design/admx_pkg.sv
// Purpose: Types for the multiplexed address/data bus controller
// Assumes: Included header supplies the numeric constants
// Notes: Gray codes run along the usual state path
`include "admx_params.svh"
package admx_pkg;
  // ========================================================
  // Bus cycle state machine
  typedef enum logic [3:0] {
    ADMX_IDLE = 4'h0,
    ADMX_CSX_PRE = 4'h1,
    ADMX_ADDR_ONE = 4'h3,
    ADMX_ADDR_WAIT = 4'h2,
    ADMX_ADDR_TWO = 4'h6,
    ADMX_DATA_ONE = 4'h7,
    ADMX_DATA_TWO = 4'h5,
    ADMX_DATA_WAIT = 4'h4,
    ADMX_DATA_THREE = 4'hC,
    ADMX_CSX_POST = 4'hD
  } admx_state_e;

  // Access request from the internal bus
  typedef struct packed {
    logic [`ADMX_ADDR_W-1:0] addr;
    logic [2:0] area;
    logic write;
    logic upper_valid;
    logic lower_valid;
    logic [`ADMX_DATA_W-1:0] wdata;
  } admx_req_s;

  // Per-area timing configuration
  typedef struct packed {
    logic [`ADMX_AREAS-1:0] area_width_high;
    logic [`ADMX_AREAS-1:0] area_width_low;
    logic [`ADMX_AREAS-1:0] three_state;
    logic [`ADMX_AREAS-1:0] read_negation_late;
    logic [`ADMX_AREAS-1:0] csx_head;
    logic [`ADMX_AREAS-1:0] csx_tail;
    logic [`ADMX_AREAS*`ADMX_WAIT_W-1:0] prog_waits;
    logic pin_wait_enable;
  } admx_cfg_s;
endpackage

// file: test/admx_bus_monitor.sv
// Purpose: Port checks for admx_bus
// Assumes: Pins lag the state by one cycle
// Notes: Bound to the design at the foot of this file
`timescale 1ns/100ps
module admx_bus_monitor
  import admx_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire admx_req_s req,
  input wire logic req_done,
  input wire logic [7:0] area_mux_enable,
  input wire logic address_cycle_extend,
  input wire admx_cfg_s cfg,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic [7:0] area_select_n,
  input wire logic address_hold_strobe_n,
  input wire logic read_strobe_n,
  input wire logic read_write_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic cycle_start_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic w8;
  // ===========================================
  // Address phase, select, strobe, direction and completion checks
  assign w8 = cfg.area_width_high[req.area] & cfg.area_width_low[req.area];
  sequence s_ah_start;
    $fell(address_hold_strobe_n);
  endsequence
  a_done_single: assert property (req_done |=> !req_done)
    else $error("done pulse too long");
  a_addr_pins: assert property (s_ah_start |->
    addr_out == req.addr[ADDR_W-1:0] && data_out[7:0] == req.addr[7:0])
    else $error("address not on pins");
  a_addr_wide: assert property ((s_ah_start and !w8) |->
    data_out == req.addr[15:0] && data_oe == 16'hFFFF)
    else $error("wide address wrong");
  a_upper_unused: assert property (req_valid && w8 |->
    data_oe[15:8] == 8'h00) else $error("upper pins driven");
  a_ext_three: assert property ((s_ah_start and address_cycle_extend)
    |=> !address_hold_strobe_n ##1 !address_hold_strobe_n
    ##1 address_hold_strobe_n) else $error("extended hold wrong");
  a_no_stretch: assert property (
    (s_ah_start and !address_cycle_extend)
    |=> !address_hold_strobe_n ##1 address_hold_strobe_n)
    else $error("address phase stretched");
  a_sel_start: assert property (s_ah_start |->
    !area_select_n[req.area] && !cycle_start_flag_n)
    else $error("select or start missing");
  a_mux_only: assert property (s_ah_start |->
    area_mux_enable[req.area] && req.area >= 3'h3)
    else $error("cycle on non mux area");
  a_read_free: assert property (!read_strobe_n |->
    data_oe == 16'h0000) else $error("pins driven in read");
  a_upper_wide: assert property (!upper_byte_write_strobe_n |-> !w8)
    else $error("upper strobe in byte area");
  a_done_bound: assert property (s_ah_start |-> ##[2:60] req_done)
    else $error("access never finished");
  a_dir_write: assert property (!lower_byte_write_strobe_n |->
    !read_write_n && data_oe[7:0] == 8'hFF)
    else $error("lower strobe without driven write");
  a_dir_read: assert property (!read_strobe_n |-> read_write_n)
    else $error("read strobe during write");
  a_read_late: assert property ($fell(read_strobe_n) &&
    !cfg.three_state[req.area] |=>
    read_strobe_n == !cfg.read_negation_late[req.area])
    else $error("read negation timing wrong");
  a_head_ext: assert property ($fell(area_select_n[req.area]) &&
    cfg.csx_head[req.area] |=> $fell(address_hold_strobe_n))
    else $error("leading select extension missing");
  a_head_none: assert property ($fell(area_select_n[req.area]) &&
    !cfg.csx_head[req.area] |-> $fell(address_hold_strobe_n))
    else $error("select starts early");
endmodule
bind admx_bus admx_bus_monitor #(.ADDR_W(ADDR_W)) i_mon (.*);

// file: test/admx_periph.sv
// Purpose: Peripheral on the multiplexed pins
// Assumes: Address latched while hold is low
// Notes: Released pins toggle every cycle
`timescale 1ns/100ps
module admx_periph (
  input wire logic ref_clk,
  input wire logic [15:0] pins,
  input wire logic ah_n,
  input wire logic rd_n,
  input wire logic uw_n,
  input wire logic lw_n,
  input wire logic [2:0] slow,
  output logic [15:0] pd,
  output logic [15:0] wcap,
  output logic wait_n
);
  logic [7:0] lat = 8'h00;
  logic [15:0] junk = 16'h0000;
  logic [2:0] cnt = 3'h0;
  // Latch address, capture written bytes, count stall cycles
  always @(posedge ref_clk) begin
    junk <= ~junk;
    cnt <= (rd_n && uw_n && lw_n) ? 3'h0 : cnt + {2'h0, cnt != slow};
    if (!ah_n) begin
      lat <= pins[7:0];
      wcap <= 16'h0000;
    end
    if (!lw_n) wcap[7:0] <= pins[7:0];
    if (!uw_n) wcap[15:8] <= pins[15:8];
  end
  // Read data only while strobed, stall while counting
  assign pd = rd_n ? junk : {lat ^ 8'h5A, lat ^ 8'h3C};
  assign wait_n = (rd_n && uw_n && lw_n) || cnt == slow;
endmodule

// file: test/admx_bus_tb.sv
// Purpose: Self-checking bench for admx_bus
// Assumes: One access at a time, held until done
// Notes: Expected results queued by the driver
`timescale 1ns/100ps
module admx_bus_tb;
  import admx_pkg::*;
  logic ref_clk = 0;
  logic rstn = 0;
  logic req_valid = 0;
  admx_req_s req = '0;
  logic [7:0] area_mux_enable = 8'hF8;
  logic address_cycle_extend = 0;
  admx_cfg_s cfg = '0;
  logic [2:0] slow = 3'h0;
  logic req_done, address_hold_strobe_n, read_strobe_n, wait_n;
  logic upper_byte_write_strobe_n, lower_byte_write_strobe_n;
  logic [15:0] rdata, data_out, data_oe, data_in, pd, wcap;
  logic [23:0] addr_out;
  logic [7:0] area_select_n;
  logic [15:0] q[$];
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  assign data_in = (data_oe & data_out) | (~data_oe & pd);
  admx_bus i_dut (.ref_clk, .rstn, .req_valid, .req, .req_done, .rdata,
    .area_mux_enable, .address_cycle_extend, .cfg, .addr_out, .data_out,
    .data_oe, .data_in, .area_select_n, .address_hold_strobe_n,
    .read_strobe_n, .read_write_n(), .upper_byte_write_strobe_n,
    .lower_byte_write_strobe_n, .cycle_start_flag_n(), .wait_n);
  admx_periph i_per (.ref_clk, .pins(data_in), .ah_n(address_hold_strobe_n),
    .rd_n(read_strobe_n), .uw_n(upper_byte_write_strobe_n),
    .lw_n(lower_byte_write_strobe_n), .slow, .pd, .wcap, .wait_n);
  // ===========================================
  // Checking
  task automatic chk(logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watcher: compare each finished access, cut a hang short
  always @(negedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      close_out();
    end else if (req_done) begin
      if (q.size() == 0) num_errors++;
      else chk(q.pop_front(), req.write ? wcap : rdata);
    end
  end
  // ===========================================
  // Driver
  task automatic acc(logic [2:0] a, logic w);
    logic [15:0] d;
    logic [7:0] lo;
    d = 16'($urandom);
    req.addr = 24'($urandom);
    req.area = a;
    req.write = w;
    req.upper_valid = !cfg.area_width_high[a] && d[8];
    req.lower_valid = !req.upper_valid || d[0];
    req.wdata = d;
    lo = req.addr[7:0];
    if (w) q.push_back({req.upper_valid ? d[15:8] : 8'h00,
                        req.lower_valid ? d[7:0] : 8'h00});
    else q.push_back({cfg.area_width_high[a] ? 8'h00 : lo ^ 8'h5A, lo ^ 8'h3C});
    req_valid = 1;
    for (int i = 0; i < 80 && req_done !== 1'b1; i++) @(negedge ref_clk);
    req_valid = 0;
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    void'($urandom(32'hDB344F2B));
    repeat (4) @(negedge ref_clk);
    rstn = 1;
    for (int t = 0; t < 60; t++) begin
      cfg = 73'({$urandom, $urandom, $urandom});
      cfg.area_width_low = 8'hFF;
      cfg.csx_tail[3 + t % 5] = cfg.csx_tail[3 + t % 5] | !t[2];
      address_cycle_extend = t[1];
      slow = 3'($urandom);
      acc(3'(3 + t % 5), t[2]);
      $display("access %0d done", t);
    end
    for (int k = 0; k < 2; k++) begin
      area_mux_enable = k ? 8'hD8 : 8'hFF;
      req.area = k ? 3'h5 : 3'h2;
      req_valid = 1;
      repeat (20) @(negedge ref_clk);
      req_valid = 0;
      chk(16'(q.size()), 16'h0000);
      $display("refusal %0d done", k);
    end
    close_out();
  end
endmodule
